//--- shared/sram_ctl_cfg.svh
// Purpose: offsets, field positions, reset values and keys of the sram controller
// Assumes: 32-bit register port, byte offsets below
// Notes:   memory word index space: bank0, bank1, bank2, cache bank in that order
`ifndef SRAM_CTL_CFG_SVH
`define SRAM_CTL_CFG_SVH

`define OFS_MAP_CONFIG    8'h00
`define OFS_CODING_CTRL   8'h0C
`define OFS_CODING_STAT   8'h10
`define OFS_ERR_BANK0     8'h14
`define ERR_BANK_STRIDE   8'h0C
`define OFS_KEY0          8'h40
`define OFS_KEY1          8'h44
`define OFS_CACHE_SETUP   8'h48

`define KEY0_VALUE        32'h8D5F9FEC
`define KEY1_VALUE        32'hCDFAA5C8

`define MAP_CONFIG_RST    2'h0
`define CODING_CTRL_RST   9'h0C7
`define CACHE_SETUP_RST   1'h1

`define FLD_BANK0_DATA    0
`define FLD_CACHE_SRAM    1
`define FLD_INT_UNCOR     5
`define FLD_INT_CORR      6

`define BANK0_INSTR_BASE  32'h1000_0000
`define BANK0_DATA_BASE   32'h2001_8000
`define BANK1_BASE        32'h2000_0000
`define BANK2_BASE        32'h2000_8000
`define BANK0_BYTES       32'h0000_8000
`define BANK1_BYTES       32'h0000_8000
`define BANK2_BYTES       32'h0001_0000
`define CACHE_BYTES       32'h0000_2000

`define B0_WBASE          16'h0000
`define B1_WBASE          16'h2000
`define B2_WBASE          16'h4000
`define BC_WBASE          16'h8000
`define MEM_WORDS         34816

`endif

//--- shared/sram_ctl_pkg.sv
// Purpose: types shared by the sram controller
// Assumes: constants live in sram_ctl_cfg.svh
// Notes:   bank code 3 is the cache bank
package sram_ctl_pkg;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_RD   = 2'b01,
    S_MRG  = 2'b10
  } mem_state_t;

  typedef struct packed {
    logic        hit;
    logic [1:0]  bank;
    logic [15:0] widx;
  } dec_t;

endpackage : sram_ctl_pkg

//--- rtl/sram_bank_map_ecc_controller.sv
// Purpose: four-bank sram with address map, secded coding and error capture
// Assumes: one access in flight; MEM_REQ pulsed only while no access is pending
// Notes:   cache bank errors are recorded against bank 0, whose space it extends
//
// Local design decisions: the strobed register port and the address map.
`include "sram_ctl_cfg.svh"
`timescale 1ns/1ps
module sram_bank_map_ecc_controller
  import sram_ctl_pkg::*;
(
  // clock and reset
  input  wire logic        MCLK,
  input  wire logic        NRST,
  // memory access port
  input  wire logic        MEM_REQ,
  input  wire logic        MEM_WE,
  input  wire logic [1:0]  MEM_SIZE,
  input  wire logic [31:0] MEM_ADDR,
  input  wire logic [31:0] MEM_WDATA,
  output logic [31:0]      MEM_RDATA,
  output logic             MEM_READY,
  output logic             MEM_ERR,
  // register port
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic [31:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic [31:0]      REG_RDATA,
  // per-bank coding error interrupts
  output logic [2:0]       ECC_IRQ
);

  // n-th 7-bit column of weight three, each data bit a distinct combination
  function automatic logic [6:0] hs_col(input int n);
    int k;
    logic [6:0] c;
    k = 0;
    c = 7'h00;
    for (int v = 0; v < 128; v++) begin
      if ($countones(7'(v)) == 3) begin
        if (k == n) c = 7'(v);
        k++;
      end
    end
    return c;
  endfunction : hs_col

  function automatic logic [6:0] enc(input logic [31:0] d);
    logic [6:0] p;
    p = 7'h00;
    for (int i = 0; i < 32; i++) begin
      if (d[i]) p = p ^ hs_col(i);
    end
    return p;
  endfunction : enc

  function automatic logic [3:0] lanes(input logic [1:0] sz, input logic [1:0] a);
    logic [3:0] m;
    unique case (sz)
      2'h0:    m = 4'h1 << a;
      2'h1:    m = a[1] ? 4'hC : 4'h3;
      default: m = 4'hF;
    endcase
    return m;
  endfunction : lanes

  function automatic logic in_rng(input logic [31:0] a, input logic [31:0] b,
                                  input logic [31:0] n);
    return (a >= b) && (a < b + n);
  endfunction : in_rng

  function automatic dec_t decode(input logic [31:0] a, input logic bank0_data_select,
                                  input logic csram);
    dec_t       d;
    logic [31:0] b0;
    logic [31:0] off;
    d   = '0;
    b0  = bank0_data_select ? `BANK0_DATA_BASE : `BANK0_INSTR_BASE;
    off = 32'h0;
    if (in_rng(a, `BANK1_BASE, `BANK1_BYTES)) begin
      off  = a - `BANK1_BASE;
      d    = '{1'b1, 2'd1, `B1_WBASE + {3'h0, off[14:2]}};
    end else if (in_rng(a, `BANK2_BASE, `BANK2_BYTES)) begin
      off  = a - `BANK2_BASE;
      d    = '{1'b1, 2'd2, `B2_WBASE + {2'h0, off[15:2]}};
    end else if (in_rng(a, b0, `BANK0_BYTES)) begin
      off  = a - b0;
      d    = '{1'b1, 2'd0, `B0_WBASE + {3'h0, off[14:2]}};
    end else if (csram && in_rng(a, b0 + `BANK0_BYTES, `CACHE_BYTES)) begin
      off  = a - b0 - `BANK0_BYTES;
      d    = '{1'b1, 2'd3, `BC_WBASE + {5'h00, off[12:2]}};
    end
    return d;
  endfunction : decode

  // one word store for all four banks, 32 data plus 7 check bits
  logic [38:0] mem [0:`MEM_WORDS-1];

  mem_state_t  state_r;
  logic [1:0]  map_cfg_r;
  logic        cache_en_r;
  logic [8:0]  ctl_r;
  logic        unlock0_r;
  logic        unlock1_r;
  logic [5:0]  stat_r;
  logic [31:0] cur_a_r [0:2];
  logic [31:0] cur_d_r [0:2];
  logic [6:0]  cur_p_r [0:2];
  logic [31:0] lat_a_r [0:2];
  logic [31:0] lat_d_r [0:2];
  logic [6:0]  lat_p_r [0:2];
  logic [38:0] q_r;
  logic [31:0] acc_a_r;
  logic [31:0] acc_wd_r;
  logic [1:0]  acc_sz_r;
  logic [1:0]  acc_bank_r;
  logic [15:0] acc_widx_r;

  logic        csram;
  dec_t        dec;
  logic [1:0]  ebank;
  logic        chk_en;
  logic [6:0]  syn;
  logic [31:0] fixed;
  logic        err_one;
  logic        err_two;
  logic        err_any;
  logic [31:0] merged;
  logic [3:0]  m;
  logic        stat_rd;
  logic        stat_clr;
  logic        can_cap;

  // cache-as-sram only counts while cache enable is zero
  assign csram = map_cfg_r[`FLD_CACHE_SRAM] & ~cache_en_r;
  assign dec   = decode(MEM_ADDR, map_cfg_r[`FLD_BANK0_DATA], csram);
  assign ebank = (acc_bank_r == 2'd3) ? 2'd0 : acc_bank_r;
  assign chk_en = ctl_r[ebank];

  // syndrome decode: weight-3 match flips a data bit, weight-1 is a check bit
  always_comb begin
    syn     = q_r[38:32] ^ enc(q_r[31:0]);
    fixed   = q_r[31:0];
    err_one = 1'b0;
    err_two = 1'b0;
    if (chk_en && syn != 7'h00) begin
      if ($countones(syn) == 1) begin
        err_one = 1'b1;
      end else begin
        err_two = 1'b1;
        for (int i = 0; i < 32; i++) begin
          if (syn == hs_col(i)) begin
            fixed[i] = ~fixed[i];
            err_one  = 1'b1;
            err_two  = 1'b0;
          end
        end
      end
    end
  end
  assign err_any = err_one | err_two;

  // merge new lanes over the corrected old word
  always_comb begin
    m      = lanes(acc_sz_r, acc_a_r[1:0]);
    merged = fixed;
    for (int b = 0; b < 4; b++) begin
      if (m[b]) merged[8*b +: 8] = acc_wd_r[8*b +: 8];
    end
  end

  // access sequencer
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      state_r <= S_IDLE;
    end else begin
      unique case (state_r)
        S_IDLE: begin
          if (MEM_REQ && dec.hit && !(MEM_WE && MEM_SIZE == 2'h2)) begin
            state_r <= MEM_WE ? S_MRG : S_RD;
          end
        end
        S_RD:  state_r <= S_IDLE;
        S_MRG: state_r <= S_IDLE;
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // memory array port: synchronous read, single write
  always_ff @(posedge MCLK) begin
    if (state_r == S_IDLE && MEM_REQ && dec.hit) begin
      q_r <= mem[dec.widx];
      if (MEM_WE && MEM_SIZE == 2'h2) begin
        mem[dec.widx] <= {enc(MEM_WDATA), MEM_WDATA};
      end
    end else if (state_r == S_MRG) begin
      mem[acc_widx_r] <= {enc(merged), merged};
    end
  end

  // access context
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      acc_a_r    <= 32'h0;
      acc_wd_r   <= 32'h0;
      acc_sz_r   <= 2'h0;
      acc_bank_r <= 2'h0;
      acc_widx_r <= 16'h0;
    end else if (state_r == S_IDLE && MEM_REQ) begin
      acc_a_r    <= MEM_ADDR;
      acc_wd_r   <= MEM_WDATA;
      acc_sz_r   <= MEM_SIZE;
      acc_bank_r <= dec.bank;
      acc_widx_r <= dec.widx;
    end
  end

  // answer: unmapped or cache-owned space gives a bus error
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      MEM_READY <= 1'b0;
      MEM_ERR   <= 1'b0;
      MEM_RDATA <= 32'h0;
    end else begin
      MEM_READY <= (state_r == S_IDLE && MEM_REQ &&
                    (!dec.hit || (MEM_WE && MEM_SIZE == 2'h2))) ||
                   state_r == S_RD || state_r == S_MRG;
      MEM_ERR   <= state_r == S_IDLE && MEM_REQ && !dec.hit;
      if (state_r == S_RD) MEM_RDATA <= fixed;
    end
  end

  // key unlock, one protected write per key
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      unlock0_r <= 1'b0;
      unlock1_r <= 1'b0;
    end else if (REG_WR) begin
      if (REG_ADDR == `OFS_KEY0) unlock0_r <= REG_WDATA == `KEY0_VALUE;
      else if (REG_ADDR == `OFS_MAP_CONFIG) unlock0_r <= 1'b0;
      if (REG_ADDR == `OFS_KEY1) unlock1_r <= REG_WDATA == `KEY1_VALUE;
      else if (REG_ADDR == `OFS_CODING_CTRL) unlock1_r <= 1'b0;
    end
  end

  // configuration registers
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      map_cfg_r  <= `MAP_CONFIG_RST;
      ctl_r      <= `CODING_CTRL_RST;
      cache_en_r <= `CACHE_SETUP_RST;
    end else if (REG_WR) begin
      if (REG_ADDR == `OFS_MAP_CONFIG && unlock0_r) map_cfg_r <= REG_WDATA[1:0];
      if (REG_ADDR == `OFS_CODING_CTRL && unlock1_r) ctl_r <= REG_WDATA[8:0];
      if (REG_ADDR == `OFS_CACHE_SETUP) cache_en_r <= REG_WDATA[0];
    end
  end

  assign stat_rd  = REG_RD && REG_ADDR == `OFS_CODING_STAT;
  assign stat_clr = stat_rd && ctl_r[8];
  assign can_cap  = (stat_r[2*ebank +: 2] == 2'b00) || stat_clr;

  // status: one set per bank, a new error wins over a clearing read
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      stat_r <= 6'h00;
    end else begin
      for (int b = 0; b < 3; b++) begin
        if (stat_clr) stat_r[2*b +: 2] <= 2'b00;
        if ((state_r == S_RD || state_r == S_MRG) && err_any && can_cap &&
            ebank == 2'(b)) begin
          stat_r[2*b +: 2] <= {err_two, err_one};
        end
      end
    end
  end

  // current and latched error records
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      for (int b = 0; b < 3; b++) begin
        cur_a_r[b] <= 32'h0;
        cur_d_r[b] <= 32'h0;
        cur_p_r[b] <= 7'h00;
        lat_a_r[b] <= 32'h0;
        lat_d_r[b] <= 32'h0;
        lat_p_r[b] <= 7'h00;
      end
    end else begin
      for (int b = 0; b < 3; b++) begin
        if (stat_rd) begin
          lat_a_r[b] <= cur_a_r[b];
          lat_d_r[b] <= cur_d_r[b];
          lat_p_r[b] <= cur_p_r[b];
        end
        if (stat_clr) begin
          cur_a_r[b] <= 32'h0;
          cur_d_r[b] <= 32'h0;
          cur_p_r[b] <= 7'h00;
        end
        if ((state_r == S_RD || state_r == S_MRG) && err_any && can_cap &&
            ebank == 2'(b)) begin
          cur_a_r[b] <= {acc_a_r[31:2], 2'b00};
          cur_d_r[b] <= q_r[31:0];
          cur_p_r[b] <= q_r[38:32];
        end
      end
    end
  end

  // interrupt per bank, filtered by error type
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      ECC_IRQ <= 3'h0;
    end else begin
      for (int b = 0; b < 3; b++) begin
        ECC_IRQ[b] <= (ctl_r[`FLD_INT_UNCOR] & stat_r[2*b+1]) |
                      (ctl_r[`FLD_INT_CORR] & stat_r[2*b]);
      end
    end
  end

  // register read, data one cycle after the strobe
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      REG_RDATA <= 32'h0;
    end else if (REG_RD) begin
      REG_RDATA <= 32'h0;
      unique case (REG_ADDR)
        `OFS_MAP_CONFIG:  REG_RDATA <= {30'h0, map_cfg_r};
        `OFS_CODING_CTRL: REG_RDATA <= {23'h0, ctl_r};
        `OFS_CODING_STAT: REG_RDATA <= {26'h0, stat_r};
        `OFS_CACHE_SETUP: REG_RDATA <= {31'h0, cache_en_r};
        default: begin
          for (int b = 0; b < 3; b++) begin
            // record type 0 shows current, others the latched copy
            if (REG_ADDR == `OFS_ERR_BANK0 + 8'(b) * `ERR_BANK_STRIDE) begin
              REG_RDATA <= (ctl_r[8:7] == 2'h0) ? cur_a_r[b] : lat_a_r[b];
            end
            if (REG_ADDR == `OFS_ERR_BANK0 + 8'(b) * `ERR_BANK_STRIDE + 8'h04) begin
              REG_RDATA <= (ctl_r[8:7] == 2'h0) ? cur_d_r[b] : lat_d_r[b];
            end
            if (REG_ADDR == `OFS_ERR_BANK0 + 8'(b) * `ERR_BANK_STRIDE + 8'h08) begin
              REG_RDATA <= {25'h0, (ctl_r[8:7] == 2'h0) ? cur_p_r[b] : lat_p_r[b]};
            end
          end
        end
      endcase
    end
  end

  property p_unmapped_err;
    @(posedge MCLK) disable iff (!NRST)
      (state_r == S_IDLE && MEM_REQ && !dec.hit) |=> (MEM_ERR && MEM_READY);
  endproperty
  a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped access no error");

  property p_cache_owned;
    @(posedge MCLK) disable iff (!NRST)
      (cache_en_r && MEM_REQ && state_r == S_IDLE && MEM_ADDR[31:28] == 4'h1 &&
       MEM_ADDR[27:0] >= 28'h000_8000 && MEM_ADDR[27:0] < 28'h000_A000) |=> MEM_ERR;
  endproperty
  a_cache_owned: assert property (p_cache_owned) else $error("cache bank reachable");

  property p_key_guard;
    @(posedge MCLK) disable iff (!NRST)
      (REG_WR && REG_ADDR == `OFS_MAP_CONFIG && !unlock0_r) |=> $stable(map_cfg_r);
  endproperty
  a_key_guard: assert property (p_key_guard) else $error("config changed without key");

  property p_rmw_seq;
    @(posedge MCLK) disable iff (!NRST)
      (state_r == S_IDLE && MEM_REQ && MEM_WE && MEM_SIZE != 2'h2 && dec.hit)
      |=> state_r == S_MRG ##1 (MEM_READY && !MEM_ERR);
  endproperty
  a_rmw_seq: assert property (p_rmw_seq) else $error("narrow write skipped merge");

  property p_hold_record;
    @(posedge MCLK) disable iff (!NRST)
      (stat_r[1:0] != 2'b00 && !stat_clr) |=> $stable(cur_a_r[0]);
  endproperty
  a_hold_record: assert property (p_hold_record) else $error("record overwritten");

  property p_latch_copy;
    @(posedge MCLK) disable iff (!NRST)
      stat_rd |=> lat_a_r[1] == $past(cur_a_r[1]);
  endproperty
  a_latch_copy: assert property (p_latch_copy) else $error("latch copy missed");

  property p_type0_sticky;
    @(posedge MCLK) disable iff (!NRST)
      (stat_rd && !ctl_r[8]) |=> (($past(stat_r) & ~stat_r) == 6'h00);
  endproperty
  a_type0_sticky: assert property (p_type0_sticky) else $error("status cleared wrongly");

  property p_irq_from_status;
    @(posedge MCLK) disable iff (!NRST)
      (stat_r[3] && ctl_r[`FLD_INT_UNCOR]) |=> ECC_IRQ[1];
  endproperty
  a_irq_from_status: assert property (p_irq_from_status) else $error("irq missing");

  property p_single_flag;
    @(posedge MCLK) disable iff (!NRST)
      (state_r == S_RD && err_one && ebank == 2'd2 && stat_r[5:4] == 2'b00)
      |=> (stat_r[5:4] == 2'b01 && MEM_RDATA == $past(fixed));
  endproperty
  a_single_flag: assert property (p_single_flag) else $error("single error not flagged");

endmodule : sram_bank_map_ecc_controller

//--- tb/bus_master_model.sv
// Purpose: bus master on the memory port, one access at a time
// Assumes: answer within 8 cycles of the taking edge
// Notes:   released address and data lines show the inverse of their last value
`timescale 1ns/1ps
module bus_master_model (
  // clock
  input  wire logic        mclk,
  // request side
  output logic             req,
  output logic             we,
  output logic [1:0]       size,
  output logic [31:0]      addr,
  output logic [31:0]      wdata,
  // answer side
  input  wire logic [31:0] rdata,
  input  wire logic        ready,
  input  wire logic        err
);
  initial begin
    req   = 1'b0;
    we    = 1'b0;
    size  = 2'h2;
    addr  = 32'h0;
    wdata = 32'h0;
  end

  task automatic xfer(input logic w, input logic [1:0] sz, input logic [31:0] a,
                      input logic [31:0] d, output logic [31:0] rd, output logic er,
                      output logic ok);
    int i;
    ok = 1'b0;
    rd = 32'h0;
    er = 1'b0;
    @(posedge mclk);
    req   <= 1'b1;
    we    <= w;
    size  <= sz;
    addr  <= a;
    wdata <= d;
    @(posedge mclk);
    req <= 1'b0;
    for (i = 0; i < 8 && !ok; i++) begin
      @(posedge mclk);
      if (ready === 1'b1) begin
        ok = 1'b1;
        rd = rdata;
        er = err;
      end
    end
    addr  <= ~a;
    wdata <= ~d;
  endtask : xfer
endmodule : bus_master_model

//--- tb/tb.sv
// Purpose: register and memory-map checks of the sram controller
// Assumes: stored bit errors injected by writing the array directly; one bank 2 single-bit error checked
// Notes:   memory port driven by the master model
`include "sram_ctl_cfg.svh"
`timescale 1ns/1ps
module tb
  import sram_ctl_pkg::*;
;
  logic        mclk;
  logic        rst_n;
  logic        req;
  logic        we;
  logic [1:0]  size;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        ready;
  logic        err;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic [2:0]  irq;
  int          n_errors;
  int          compares;
  logic [31:0] ta [5];
  int          i;

  initial mclk = 1'b0;
  always #2 mclk = ~mclk;

  sram_bank_map_ecc_controller uut (
    .MCLK(mclk), .NRST(rst_n), .MEM_REQ(req), .MEM_WE(we), .MEM_SIZE(size),
    .MEM_ADDR(addr), .MEM_WDATA(wdata), .MEM_RDATA(rdata), .MEM_READY(ready),
    .MEM_ERR(err), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
    .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .ECC_IRQ(irq));

  bus_master_model m (
    .mclk(mclk), .req(req), .we(we), .size(size), .addr(addr), .wdata(wdata),
    .rdata(rdata), .ready(ready), .err(err));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic mem(input logic w, input logic [1:0] sz, input logic [31:0] a,
                     input logic [31:0] d, input logic xe);
    logic [31:0] rd;
    logic        er;
    logic        ok;
    m.xfer(w, sz, a, d, rd, er, ok);
    chk({31'h0, ok}, 32'h1);
    chk({31'h0, er}, {31'h0, xe});
    if (!w && !xe) chk(rd, d);
  endtask : mem

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
    chk(reg_rdata, exp);
  endtask : rdc

  task automatic finish_test;
    $display("errors=%0d compares=%0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test

  initial begin
    #40000;
    n_errors++;
    finish_test;
  end

  initial begin
    n_errors  = 0;
    compares  = 0;
    rst_n     = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 32'h0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    rdc(`OFS_MAP_CONFIG, 32'h0);
    rdc(`OFS_CODING_CTRL, 32'h0000_00C7);
    rdc(`OFS_CACHE_SETUP, 32'h1);
    rdc(`OFS_CODING_STAT, 32'h0);
    rdc(8'h3C, 32'h0);
    ta = '{32'h1000_0000, 32'h1000_7FFC, 32'h2000_0000, 32'h2000_8000, 32'h2001_7FFC};
    for (i = 0; i < 5; i++) begin
      mem(1'b1, 2'h2, ta[i], 32'hA5C3_0000 + i, 1'b0);
      mem(1'b0, 2'h2, ta[i], 32'hA5C3_0000 + i, 1'b0);
    end
    mem(1'b0, 2'h2, 32'h2001_8000, 32'h0, 1'b1);
    mem(1'b0, 2'h2, 32'h1000_8000, 32'h0, 1'b1);
    mem(1'b0, 2'h2, 32'h0FFF_FFFC, 32'h0, 1'b1);
    mem(1'b1, 2'h0, 32'h2000_0001, 32'h0000_AA00, 1'b0);
    mem(1'b0, 2'h2, 32'h2000_0000, 32'hA5C3_AA02, 1'b0);
    mem(1'b1, 2'h1, 32'h2000_0002, 32'hBEEF_0000, 1'b0);
    mem(1'b0, 2'h2, 32'h2000_0000, 32'hBEEF_AA02, 1'b0);
    wr(`OFS_MAP_CONFIG, 32'h1);
    rdc(`OFS_MAP_CONFIG, 32'h0);
    wr(`OFS_KEY0, `KEY0_VALUE);
    rdc(`OFS_KEY0, 32'h0);
    wr(`OFS_MAP_CONFIG, 32'h1);
    rdc(`OFS_MAP_CONFIG, 32'h1);
    mem(1'b0, 2'h2, 32'h2001_8000, 32'hA5C3_0000, 1'b0);
    mem(1'b0, 2'h2, 32'h1000_0000, 32'h0, 1'b1);
    wr(`OFS_MAP_CONFIG, 32'h3);
    rdc(`OFS_MAP_CONFIG, 32'h1);
    wr(`OFS_KEY0, `KEY0_VALUE);
    wr(`OFS_MAP_CONFIG, 32'h3);
    mem(1'b0, 2'h2, 32'h2002_0000, 32'h0, 1'b1);
    wr(`OFS_CACHE_SETUP, 32'h0);
    rdc(`OFS_CACHE_SETUP, 32'h0);
    mem(1'b1, 2'h2, 32'h2002_0000, 32'h5A00_00C1, 1'b0);
    mem(1'b1, 2'h2, 32'h2002_1FFC, 32'h5A00_00C2, 1'b0);
    mem(1'b0, 2'h2, 32'h2002_1FFC, 32'h5A00_00C2, 1'b0);
    mem(1'b0, 2'h2, 32'h2002_2000, 32'h0, 1'b1);
    wr(`OFS_KEY0, `KEY0_VALUE);
    wr(`OFS_MAP_CONFIG, 32'h2);
    mem(1'b0, 2'h2, 32'h1000_8000, 32'h5A00_00C1, 1'b0);
    mem(1'b0, 2'h2, 32'h2002_0000, 32'h0, 1'b1);
    wr(`OFS_CACHE_SETUP, 32'h1);
    mem(1'b0, 2'h2, 32'h1000_8000, 32'h0, 1'b1);
    wr(`OFS_CODING_CTRL, 32'h0000_0187);
    rdc(`OFS_CODING_CTRL, 32'h0000_00C7);
    wr(`OFS_KEY1, `KEY1_VALUE);
    wr(`OFS_CODING_CTRL, 32'h0000_01E7);
    rdc(`OFS_CODING_CTRL, 32'h0000_01E7);
    rdc(`OFS_CODING_STAT, 32'h0);
    rdc(`OFS_ERR_BANK0, 32'h0);
    // flip one stored bit of the first bank 2 word, then read it back corrected
    uut.mem[16'h4000] = uut.mem[16'h4000] ^ 39'h1;
    mem(1'b0, 2'h2, 32'h2000_8000, 32'hA5C3_0003, 1'b0);
    @(posedge mclk);
    chk({29'h0, irq}, 32'h4);
    rdc(`OFS_CODING_STAT, 32'h10);
    rdc(8'h2C, 32'h2000_8000);
    rdc(8'h30, 32'hA5C3_0002);
    rdc(`OFS_CODING_STAT, 32'h0);
    chk({29'h0, irq}, 32'h0);
    finish_test;
  end
endmodule : tb
